// ### verilog/isr_defs.svh
// constants for the instrument status and event reporting block
`ifndef ISR_DEFS_SVH
`define ISR_DEFS_SVH

// widths
`define ISR_MASK_W        6
`define ISR_OPERATION_SUMMARY_BIT_W        16
`define ISR_STB_W         8
`define ISR_DATA_W        16
`define ISR_ERR_DEPTH     30

// mask test event flag positions
`define ISR_MT_DONE_BIT   0
`define ISR_MT_FAIL_BIT   1
`define ISR_MT_LOW_BIT    2
`define ISR_MT_HIGH_BIT   3
`define ISR_MT_ALIGN_BIT  4
`define ISR_MT_AFAIL_BIT  5

// operation status positions
`define ISR_OP_ACQ_BIT    0
`define ISR_OP_PROC_BIT   1
`define ISR_OP_ARM_BIT    5
`define ISR_OP_MASK_BIT   9
`define ISR_OP_AUTO_BIT   11

// status byte positions
`define ISR_STB_MSG_BIT   2
`define ISR_STB_MAV_BIT   4
`define ISR_STB_RQS_BIT   6
`define ISR_STB_OPERATION_SUMMARY_BIT_BIT  7

// reset values
`define ISR_MASK_EN_RST   6'h00
`define ISR_OPERATION_SUMMARY_BIT_EN_RST   16'h0000
`define ISR_SRE_RST       8'h00

// error codes
`define ISR_ERR_NONE      16'h0000
`define ISR_ERR_OVERFLOW  16'hfea2

`endif

// ### verilog/isr_pkg.sv
// types shared by the status and event reporting block
`include "isr_defs.svh"

package isr_pkg;

  // host command and query codes taken from the parser
  typedef enum logic [4:0] {
    ISR_CMD_NONE,
    ISR_CMD_MASK_EVT_RD,
    ISR_CMD_MASK_EN_WR,
    ISR_CMD_MASK_EN_RD,
    ISR_CMD_ACQ_RD,
    ISR_CMD_PROC_RD,
    ISR_CMD_ARM_RD,
    ISR_CMD_AUTO_RD,
    ISR_CMD_OPERATION_SUMMARY_BIT_RD,
    ISR_CMD_OPERATION_SUMMARY_BIT_EN_WR,
    ISR_CMD_OPERATION_SUMMARY_BIT_EN_RD,
    ISR_CMD_SRE_WR,
    ISR_CMD_SRE_RD,
    ISR_CMD_STB_RD,
    ISR_CMD_ERR_RD,
    ISR_CMD_MSG_RD,
    ISR_CMD_CLS
  } isr_cmd_e;

  // one host command
  typedef struct packed {
    logic                     valid;
    isr_cmd_e                 op;
    logic [`ISR_DATA_W-1:0]   data;
    logic                     after_term;
  } isr_cmd_s;

  // instrument event pulses
  typedef struct packed {
    logic [`ISR_MASK_W-1:0]   mask;
    logic                     acquisition_complete_flag;
    logic                     processing_complete_flag;
    logic                     armed;
    logic                     auto_trigger_event;
  } isr_evt_s;

  // registered state of the top module, error queue aside
  typedef struct packed {
    logic [`ISR_MASK_W-1:0]   mask_evt;
    logic [`ISR_MASK_W-1:0]   mask_en;
    logic                     acq_evt;
    logic                     proc_evt;
    logic                     arm_evt;
    logic                     auto_evt;
    logic [`ISR_OPERATION_SUMMARY_BIT_W-1:0]   operation_summary_bit;
    logic [`ISR_OPERATION_SUMMARY_BIT_W-1:0]   operation_summary_bit_en;
    logic [`ISR_STB_W-1:0]    sre;
    logic                     msg_flag;
    logic [`ISR_DATA_W-1:0]   msg_text;
    logic                     req_prev;
    logic                     rqs;
    logic [`ISR_STB_W-1:0]    stb;
    logic                     rsp_valid;
    logic [`ISR_DATA_W-1:0]   rsp_data;
    logic                     outq_clr;
  } isr_state_s;

endpackage

// ### verilog/isr_err_queue.sv
// bounded error queue with overflow marker in its last slot
`timescale 1ns/1ps
`default_nettype none
`include "isr_defs.svh"

module isr_err_queue #(
  parameter int DEPTH = `ISR_ERR_DEPTH,
  parameter int W     = `ISR_DATA_W
) (
  // clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // control
  input  wire logic         push_i,
  input  wire logic [W-1:0] code_i,
  input  wire logic         pop_i,
  input  wire logic         clear_i,
  // oldest entry, none-code when empty
  output logic      [W-1:0] head_o,
  output logic              empty_o
);

  localparam int CW = $clog2(DEPTH + 1);

  // whole queue state
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] slot;   // slot 0 is the oldest
    logic [CW-1:0]           count;  // filled slots
  } isr_q_s;

  isr_q_s q_reg;
  isr_q_s q_next;
  logic [CW-1:0] cnt_pop;            // count after any pop

  // pop shifts toward the head, then a push lands at the tail
  always_comb begin
    q_next  = q_reg;
    cnt_pop = q_reg.count;
    if (pop_i && q_reg.count != '0) begin
      for (int i = 0; i < DEPTH - 1; i++) begin
        q_next.slot[i] = q_reg.slot[i+1];
      end
      cnt_pop = q_reg.count - CW'(1);
    end
    q_next.count = cnt_pop;
    if (push_i) begin
      if (cnt_pop < CW'(DEPTH - 1)) begin
        q_next.slot[cnt_pop] = code_i;
        q_next.count         = cnt_pop + CW'(1);
      end else if (cnt_pop == CW'(DEPTH - 1)) begin
        // newest error dropped, marker takes the last slot
        q_next.slot[cnt_pop] = `ISR_ERR_OVERFLOW;
        q_next.count         = cnt_pop + CW'(1);
      end
    end
    if (clear_i) begin
      q_next.count = '0;
    end
  end

  // state register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q_reg <= '0;
    end else begin
      q_reg <= q_next;
    end
  end

  // empty queue answers no-error
  assign empty_o = (q_reg.count == '0);
  assign head_o  = empty_o ? `ISR_ERR_NONE : q_reg.slot[0];

endmodule

`default_nettype wire

// ### verilog/isr_status_top.sv
// status byte, operation and mask event registers, queues and service request
`timescale 1ns/1ps
`default_nettype none
`include "isr_defs.svh"

module isr_status_top
  import isr_pkg::*;
#(
  parameter int ERR_DEPTH = `ISR_ERR_DEPTH
) (
  // clock and reset
  input  wire logic                   CLK_I,
  input  wire logic                   RST_I,
  // parsed host commands
  input  wire isr_pkg::isr_cmd_s      CMD_I,
  // status byte read by serial poll
  input  wire logic                   SERIAL_POLL_I,
  // instrument events
  input  wire isr_pkg::isr_evt_s      EVT_I,
  // error reports
  input  wire logic                   ERR_VALID_I,
  input  wire logic [`ISR_DATA_W-1:0] ERR_CODE_I,
  // output queue level
  input  wire logic                   OUTQ_NOT_EMPTY_I,
  // advisory line writes
  input  wire logic                   ADV_WR_I,
  input  wire logic                   ADV_BY_HOST_I,
  input  wire logic [`ISR_DATA_W-1:0] ADV_TEXT_I,
  // answers toward the host
  output logic                        RSP_VALID_O,
  output logic [`ISR_DATA_W-1:0]      RSP_DATA_O,
  // status toward the host
  output logic [`ISR_STB_W-1:0]       STB_O,
  output logic                        SRQ_O,
  output logic                        OUTQ_CLEAR_O
);

  import isr_pkg::*;

  isr_state_s s_reg;                          // registered state
  isr_state_s s_next;                         // next state

  logic                   cmd_go;             // command taken this cycle
  logic                   cls;                // clear status this cycle
  logic                   err_pop;            // error read pops queue
  logic [`ISR_DATA_W-1:0] err_head;           // oldest error code
  logic                   err_empty;          // error queue empty
  logic                   mask_sum;           // enabled mask flag seen
  logic [`ISR_OPERATION_SUMMARY_BIT_W-1:0] operation_summary_bit_src;           // operation bit sources
  logic                   operation_summary_bit_sum;           // enabled operation bit seen
  logic [`ISR_STB_W-1:0]  stb_sum;            // status byte without bit 6
  logic                   req_now;            // enabled status summary

  // true when the command is valid and carries the given code (clearing reads, error read, clear status)
  function automatic logic clr_rd(input isr_cmd_s c, input isr_cmd_e op);
    clr_rd = c.valid && (c.op == op);
  endfunction

  // zero-extend a narrow field into an answer word
  function automatic logic [`ISR_DATA_W-1:0] ext(input logic [`ISR_OPERATION_SUMMARY_BIT_W-1:0] v);
    ext = v;
  endfunction

  assign cmd_go  = CMD_I.valid;
  assign cls     = clr_rd(CMD_I, ISR_CMD_CLS);
  assign err_pop = clr_rd(CMD_I, ISR_CMD_ERR_RD);

  // error queue; it also empties on clear status
  isr_err_queue #(
    .DEPTH   (ERR_DEPTH),
    .W       (`ISR_DATA_W)
  ) u_err (
    .clk_i   (CLK_I),
    .rst_i   (RST_I),
    .push_i  (ERR_VALID_I),
    .code_i  (ERR_CODE_I),
    .pop_i   (err_pop),
    .clear_i (cls),
    .head_o  (err_head),
    .empty_o (err_empty)
  );

  // gated summaries, formed from current flags every clock
  always_comb begin
    // mask summary only from enabled flags
    mask_sum = |(s_reg.mask_evt & s_reg.mask_en);
    // sticky event registers feed their operation bits
    operation_summary_bit_src                    = '0;
    operation_summary_bit_src[`ISR_OP_ACQ_BIT]   = s_reg.acq_evt;
    operation_summary_bit_src[`ISR_OP_PROC_BIT]  = s_reg.proc_evt;
    operation_summary_bit_src[`ISR_OP_ARM_BIT]   = s_reg.arm_evt;
    operation_summary_bit_src[`ISR_OP_AUTO_BIT]  = s_reg.auto_evt;
    operation_summary_bit_src[`ISR_OP_MASK_BIT]  = mask_sum;
    // operation summary only from enabled bits
    operation_summary_bit_sum = |(s_reg.operation_summary_bit & s_reg.operation_summary_bit_en);
    // status byte summaries
    stb_sum                     = '0;
    stb_sum[`ISR_STB_OPERATION_SUMMARY_BIT_BIT]  = operation_summary_bit_sum;
    stb_sum[`ISR_STB_MAV_BIT]   = OUTQ_NOT_EMPTY_I;
    stb_sum[`ISR_STB_MSG_BIT]   = s_reg.msg_flag;
    // service request wanted by any enabled summary
    req_now = |(stb_sum & s_reg.sre);
  end

  // next state
  always_comb begin
    s_next           = s_reg;
    s_next.rsp_valid = 1'b0;
    s_next.rsp_data  = '0;
    s_next.outq_clr  = 1'b0;

    // clearing reads first; new events below win over them
    if (clr_rd(CMD_I, ISR_CMD_MASK_EVT_RD)) begin
      s_next.mask_evt = '0;
    end
    if (clr_rd(CMD_I, ISR_CMD_ACQ_RD)) begin
      s_next.acq_evt = 1'b0;
    end
    if (clr_rd(CMD_I, ISR_CMD_PROC_RD)) begin
      s_next.proc_evt = 1'b0;
    end
    if (clr_rd(CMD_I, ISR_CMD_ARM_RD)) begin
      s_next.arm_evt = 1'b0;
    end
    if (clr_rd(CMD_I, ISR_CMD_AUTO_RD)) begin
      s_next.auto_evt = 1'b0;
    end
    if (clr_rd(CMD_I, ISR_CMD_OPERATION_SUMMARY_BIT_RD)) begin
      s_next.operation_summary_bit = '0;
    end

    // clear status wipes every event register
    if (cls) begin
      s_next.mask_evt = '0;
      s_next.acq_evt  = 1'b0;
      s_next.proc_evt = 1'b0;
      s_next.arm_evt  = 1'b0;
      s_next.auto_evt = 1'b0;
      s_next.operation_summary_bit     = '0;
      s_next.msg_flag = 1'b0;
      // output queue too, only right after a terminator
      s_next.outq_clr = CMD_I.after_term;
    end

    // mask test flags latch whatever their enable
    s_next.mask_evt = s_next.mask_evt | EVT_I.mask;
    // sticky single-bit events
    if (EVT_I.acquisition_complete_flag) begin
      s_next.acq_evt = 1'b1;
    end
    if (EVT_I.processing_complete_flag) begin
      s_next.proc_evt = 1'b1;
    end
    if (EVT_I.armed) begin
      s_next.arm_evt = 1'b1;
    end
    if (EVT_I.auto_trigger_event) begin
      s_next.auto_evt = 1'b1;
    end
    // operation bits latch their sources whatever the enable
    s_next.operation_summary_bit = s_next.operation_summary_bit | operation_summary_bit_src;

    // advisory line: text always kept, flag only for internal messages
    if (ADV_WR_I) begin
      s_next.msg_text = ADV_TEXT_I;
      if (!ADV_BY_HOST_I) begin
        s_next.msg_flag = 1'b1;
      end
    end

    // host commands: writes update masks, reads answer next cycle
    if (cmd_go) begin
      case (CMD_I.op)
        ISR_CMD_MASK_EVT_RD: begin
          s_next.rsp_valid = 1'b1;
          s_next.rsp_data  = ext(16'(s_reg.mask_evt));
        end
        ISR_CMD_MASK_EN_WR: begin
          s_next.mask_en = CMD_I.data[`ISR_MASK_W-1:0];
        end
        ISR_CMD_MASK_EN_RD: begin
          s_next.rsp_valid = 1'b1;
          s_next.rsp_data  = ext(16'(s_reg.mask_en));
        end
        ISR_CMD_ACQ_RD: begin
          s_next.rsp_valid = 1'b1;
          s_next.rsp_data  = ext(16'(s_reg.acq_evt));
        end
        ISR_CMD_PROC_RD: begin
          s_next.rsp_valid = 1'b1;
          s_next.rsp_data  = ext(16'(s_reg.proc_evt));
        end
        ISR_CMD_ARM_RD: begin
          s_next.rsp_valid = 1'b1;
          s_next.rsp_data  = ext(16'(s_reg.arm_evt));
        end
        ISR_CMD_AUTO_RD: begin
          s_next.rsp_valid = 1'b1;
          s_next.rsp_data  = ext(16'(s_reg.auto_evt));
        end
        ISR_CMD_OPERATION_SUMMARY_BIT_RD: begin
          s_next.rsp_valid = 1'b1;
          s_next.rsp_data  = ext(s_reg.operation_summary_bit);
        end
        ISR_CMD_OPERATION_SUMMARY_BIT_EN_WR: begin
          s_next.operation_summary_bit_en = CMD_I.data;
        end
        ISR_CMD_OPERATION_SUMMARY_BIT_EN_RD: begin
          s_next.rsp_valid = 1'b1;
          s_next.rsp_data  = ext(s_reg.operation_summary_bit_en);
        end
        ISR_CMD_SRE_WR: begin
          // bit 6 of the request enable is not storable
          s_next.sre = CMD_I.data[`ISR_STB_W-1:0];
          s_next.sre[`ISR_STB_RQS_BIT] = 1'b0;
        end
        ISR_CMD_SRE_RD: begin
          s_next.rsp_valid = 1'b1;
          s_next.rsp_data  = ext(16'(s_reg.sre));
        end
        ISR_CMD_STB_RD: begin
          // plain status byte query leaves the request bit alone
          s_next.rsp_valid = 1'b1;
          s_next.rsp_data  = ext(16'(s_reg.stb));
        end
        ISR_CMD_ERR_RD: begin
          s_next.rsp_valid = 1'b1;
          s_next.rsp_data  = err_head;
        end
        ISR_CMD_MSG_RD: begin
          s_next.rsp_valid = 1'b1;
          s_next.rsp_data  = s_reg.msg_text;
        end
        ISR_CMD_CLS: begin
          // handled above
          s_next.rsp_valid = 1'b0;
        end
        default: begin
          // unknown codes are ignored
          s_next.rsp_valid = 1'b0;
        end
      endcase
    end

    // serial poll answers the status byte and drops the request bit
    if (SERIAL_POLL_I) begin
      s_next.rsp_valid = 1'b1;
      s_next.rsp_data  = ext(16'(s_reg.stb));
      s_next.rqs       = 1'b0;
    end

    // request bit rises with the first enabled summary; set beats poll
    s_next.req_prev = req_now;
    if (req_now && !s_reg.req_prev) begin
      s_next.rqs = 1'b1;
    end

    // registered status byte view
    s_next.stb                   = stb_sum;
    s_next.stb[`ISR_STB_RQS_BIT] = s_next.rqs;
  end

  // state register; masks come up disabled
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      s_reg         <= '0;
      s_reg.mask_en <= `ISR_MASK_EN_RST;
      s_reg.operation_summary_bit_en <= `ISR_OPERATION_SUMMARY_BIT_EN_RST;
      s_reg.sre     <= `ISR_SRE_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  // outputs straight from flip-flops
  assign RSP_VALID_O  = s_reg.rsp_valid;
  assign RSP_DATA_O   = s_reg.rsp_data;
  assign STB_O        = s_reg.stb;
  assign SRQ_O        = s_reg.rqs;
  assign OUTQ_CLEAR_O = s_reg.outq_clr;

endmodule

`default_nettype wire

// ### verif/isr_status_assertions.sv
// port-level checks for the status and event reporting block
`timescale 1ns/1ps
`default_nettype none
`include "isr_defs.svh"

module isr_status_assertions
  import isr_pkg::*;
#(
  parameter int ERR_DEPTH = `ISR_ERR_DEPTH
) (
  // clock and reset
  input  wire logic                   CLK_I,
  input  wire logic                   RST_I,
  // watched inputs
  input  wire isr_pkg::isr_cmd_s      CMD_I,
  input  wire logic                   SERIAL_POLL_I,
  input  wire logic                   OUTQ_NOT_EMPTY_I,
  // watched outputs
  input  wire logic                   RSP_VALID_O,
  input  wire logic [`ISR_DATA_W-1:0] RSP_DATA_O,
  input  wire logic [`ISR_STB_W-1:0]  STB_O,
  input  wire logic                   SRQ_O,
  input  wire logic                   OUTQ_CLEAR_O
);
  logic rd_req;   // a query taken this cycle
  logic cls_term; // clear status right after a terminator

  // decode of the command word
  assign rd_req = CMD_I.valid && (CMD_I.op inside {ISR_CMD_MASK_EVT_RD, ISR_CMD_MASK_EN_RD,
    ISR_CMD_ACQ_RD, ISR_CMD_PROC_RD, ISR_CMD_ARM_RD, ISR_CMD_AUTO_RD, ISR_CMD_OPERATION_SUMMARY_BIT_RD,
    ISR_CMD_OPERATION_SUMMARY_BIT_EN_RD, ISR_CMD_SRE_RD, ISR_CMD_STB_RD, ISR_CMD_ERR_RD, ISR_CMD_MSG_RD});
  assign cls_term = CMD_I.valid && (CMD_I.op == ISR_CMD_CLS) && CMD_I.after_term;

  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RST_I);

  a_read_answers: assert property (rd_req |=> RSP_VALID_O)
    else $error("query got no answer");
  a_no_stray_answer: assert property (!rd_req && !SERIAL_POLL_I |=> !RSP_VALID_O)
    else $error("answer without a query");
  a_idle_data_zero: assert property (!RSP_VALID_O |-> RSP_DATA_O == '0)
    else $error("answer data not zero while idle");
  a_srq_is_rqs: assert property (SRQ_O == STB_O[6])
    else $error("service request differs from request bit");
  a_srq_has_cause: assert property ($rose(SRQ_O) |-> STB_O[7] || STB_O[4] || STB_O[2])
    else $error("service request with no summary set");
  a_poll_clears_rqs: assert property (SERIAL_POLL_I |=> !SRQ_O || $rose(STB_O[7])
    || $rose(STB_O[4]) || $rose(STB_O[2]))
    else $error("request bit kept after serial poll");
  a_poll_reports: assert property (SERIAL_POLL_I |=> RSP_VALID_O
    && RSP_DATA_O[6] == $past(STB_O[6]))
    else $error("serial poll answer wrong");
  a_mav_set: assert property (OUTQ_NOT_EMPTY_I [*3] |-> STB_O[4])
    else $error("message available missing");
  a_mav_clear: assert property (!OUTQ_NOT_EMPTY_I [*3] |-> !STB_O[4])
    else $error("message available with empty queue");
  a_clear_follows: assert property (cls_term |-> ##[1:2] OUTQ_CLEAR_O)
    else $error("output queue clear missing");
  a_clear_cause: assert property (OUTQ_CLEAR_O |-> $past(cls_term) || $past(cls_term, 2))
    else $error("output queue clear without cause");

  // main scenarios reached
  c_err_read: cover property (rd_req && CMD_I.op == ISR_CMD_ERR_RD);
  c_poll_srq: cover property (SERIAL_POLL_I && SRQ_O);
  c_outq_clr: cover property ($rose(OUTQ_CLEAR_O));
endmodule

bind isr_status_top isr_status_assertions #(.ERR_DEPTH(ERR_DEPTH)) chk (
  .CLK_I(CLK_I), .RST_I(RST_I), .CMD_I(CMD_I), .SERIAL_POLL_I(SERIAL_POLL_I),
  .OUTQ_NOT_EMPTY_I(OUTQ_NOT_EMPTY_I), .RSP_VALID_O(RSP_VALID_O), .RSP_DATA_O(RSP_DATA_O),
  .STB_O(STB_O), .SRQ_O(SRQ_O), .OUTQ_CLEAR_O(OUTQ_CLEAR_O));
`default_nettype wire

// ### verif/isr_host_model.sv
// remote host controller: issues commands, polls and collects answers
`timescale 1ns/1ps
`default_nettype none
`include "isr_defs.svh"

module isr_host_model
  import isr_pkg::*;
(
  // clock
  input  wire logic                   CLK_I,
  // answers from the block
  input  wire logic                   RSP_VALID_I,
  input  wire logic [`ISR_DATA_W-1:0] RSP_DATA_I,
  // requests toward the block
  output var  isr_pkg::isr_cmd_s      CMD_O,
  output var  logic                   POLL_O
);
  // idle at time zero
  initial begin
    CMD_O = '0;
    POLL_O = 1'b0;
  end

  // one command for one cycle; setup writes go out with no wait for completion
  task automatic send(input isr_cmd_e op, input logic [15:0] d, input logic term);
    @(negedge CLK_I);
    CMD_O <= '{1'b1, op, d, term};
    @(negedge CLK_I);
    CMD_O <= '0;
  endtask

  // answer is taken at the falling edges after the taking edge, unknown if absent
  task automatic grab(output logic [15:0] d);
    d = 'x;
    for (int i = 0; i < 3; i++) begin
      if (RSP_VALID_I === 1'b1) begin
        d = RSP_DATA_I;
        break;
      end
      @(negedge CLK_I);
    end
  endtask

  // query and collect its answer
  task automatic rd(input isr_cmd_e op, output logic [15:0] d);
    send(op, 16'h0000, 1'b0);
    grab(d);
  endtask

  // serial poll of the status byte
  task automatic poll(output logic [15:0] d);
    @(negedge CLK_I);
    POLL_O <= 1'b1;
    @(negedge CLK_I);
    POLL_O <= 1'b0;
    grab(d);
  endtask
endmodule
`default_nettype wire

// ### verif/isr_status_top_tb.sv
// self-checking bench for the status and event reporting block
`timescale 1ns/1ps
`default_nettype none
`include "isr_defs.svh"

module isr_status_top_tb;
  import isr_pkg::*;
  logic        clk = 1'b0;      // system clock
  logic        rst = 1'b1;      // synchronous reset
  wire         isr_cmd_s cmd;   // commands from the host model
  wire         poll;            // serial poll from the host model
  isr_evt_s    evt = '0;        // instrument event pulses
  logic        err_v = 1'b0;    // error push strobe
  logic [15:0] err_c = '0;      // error code
  logic        outq = 1'b0;     // output queue holds a byte
  logic        adv_wr = 1'b0;   // advisory write strobe
  logic        adv_host = 1'b0; // advisory text from the host
  logic [15:0] adv_txt = '0;    // advisory text
  logic        rsp_v;           // answer valid
  logic [15:0] rsp_d;           // answer data
  logic [7:0]  stb;             // status byte
  logic        srq;             // service request
  logic        oclr;            // output queue clear
  int          err_count = 0;   // mismatches
  int          n_compared = 0;  // comparisons
  int          n_clr = 0;       // output queue clears seen
  logic [15:0] d;               // last answer
  isr_cmd_e    ops[4] = '{ISR_CMD_ACQ_RD, ISR_CMD_PROC_RD, ISR_CMD_ARM_RD, ISR_CMD_AUTO_RD};
  logic [15:0] bits[4] = '{16'h0001, 16'h0002, 16'h0020, 16'h0800};

  isr_status_top dut (
    .CLK_I(clk), .RST_I(rst), .CMD_I(cmd), .SERIAL_POLL_I(poll), .EVT_I(evt),
    .ERR_VALID_I(err_v), .ERR_CODE_I(err_c), .OUTQ_NOT_EMPTY_I(outq),
    .ADV_WR_I(adv_wr), .ADV_BY_HOST_I(adv_host), .ADV_TEXT_I(adv_txt),
    .RSP_VALID_O(rsp_v), .RSP_DATA_O(rsp_d), .STB_O(stb), .SRQ_O(srq),
    .OUTQ_CLEAR_O(oclr));
  isr_host_model host (.CLK_I(clk), .RSP_VALID_I(rsp_v), .RSP_DATA_I(rsp_d),
    .CMD_O(cmd), .POLL_O(poll));

  // free-running clock
  always #5 clk = ~clk;
  // count output queue clear pulses
  always @(posedge clk) if (oclr === 1'b1) n_clr <= n_clr + 1;

  // compare and report
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // verdict and end of run
  task automatic report_and_stop();
    if (err_count == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // query and compare
  task automatic rdc(input isr_cmd_e op, input logic [15:0] exp, input string nm);
    host.rd(op, d);
    check(nm, d, exp);
  endtask

  // one-cycle event pulse, then let the summary chain settle
  task automatic ev(input logic [9:0] v);
    @(negedge clk);
    evt <= v;
    @(negedge clk);
    evt <= '0;
    repeat (4) @(negedge clk);
  endtask

  // idle wait in cycles
  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask

  // hang guard
  initial begin
    repeat (5000) @(posedge clk);
    err_count++;
    report_and_stop();
  end

  // main sequence
  initial begin
    idle(6);
    rst <= 1'b0;
    idle(1);
    check("stb reset", 16'(stb), 16'h0000);
    rdc(ISR_CMD_MASK_EN_RD, 16'h0000, "mask enable reset");
    // every mask flag alone: latched, read, then gone
    for (int i = 0; i < 6; i++) begin
      ev(10'(1) << (i + 4));
      rdc(ISR_CMD_MASK_EVT_RD, 16'(1) << i, "mask flag");
      rdc(ISR_CMD_MASK_EVT_RD, 16'h0000, "mask flag cleared");
    end
    // enable only the fail flag up the chain
    host.send(ISR_CMD_MASK_EN_WR, 16'h0002, 1'b0);
    host.send(ISR_CMD_OPERATION_SUMMARY_BIT_EN_WR, 16'h0200, 1'b0);
    host.send(ISR_CMD_SRE_WR, 16'h0080, 1'b0);
    rdc(ISR_CMD_MASK_EN_RD, 16'h0002, "mask enable");
    rdc(ISR_CMD_SRE_RD, 16'h0080, "request enable");
    rdc(ISR_CMD_OPERATION_SUMMARY_BIT_EN_RD, 16'h0200, "operation_summary_bit enable");
    ev(10'h010);
    check("summary off", 16'(stb[7]), 16'h0000);
    rdc(ISR_CMD_OPERATION_SUMMARY_BIT_RD, 16'h0000, "operation_summary_bit no mask");
    ev(10'h020);
    check("summary on", 16'(stb[7]), 16'h0001);
    check("service request", 16'(srq), 16'h0001);
    host.poll(d);
    check("poll request bit", 16'(d[6]), 16'h0001);
    idle(1);
    check("request after poll", 16'(stb[6]), 16'h0000);
    rdc(ISR_CMD_MASK_EVT_RD, 16'h0003, "mask both");
    rdc(ISR_CMD_OPERATION_SUMMARY_BIT_RD, 16'h0200, "operation_summary_bit mask bit");
    idle(3);
    check("summary gone", 16'(stb[7]), 16'h0000);
    rdc(ISR_CMD_OPERATION_SUMMARY_BIT_RD, 16'h0000, "operation_summary_bit cleared");
    // sticky operation sources with their enables off
    host.send(ISR_CMD_OPERATION_SUMMARY_BIT_EN_WR, 16'h0000, 1'b0);
    for (int i = 0; i < 4; i++) begin
      ev(10'(8) >> i);
      check("disabled summary", 16'(stb[7]), 16'h0000);
      rdc(ops[i], 16'h0001, "event flag");
      rdc(ops[i], 16'h0000, "event cleared");
      rdc(ISR_CMD_OPERATION_SUMMARY_BIT_RD, bits[i], "operation_summary_bit bit");
      rdc(ISR_CMD_OPERATION_SUMMARY_BIT_RD, 16'h0000, "operation_summary_bit clear");
    end
    // event in the same cycle as its clearing read
    fork
      host.rd(ISR_CMD_ACQ_RD, d);
      ev(10'h008);
    join
    check("read beside event", d, 16'h0000);
    rdc(ISR_CMD_ACQ_RD, 16'h0001, "event kept");
    // overfill the error queue, then drain it
    for (int i = 1; i <= 31; i++) begin
      @(negedge clk);
      err_v <= 1'b1;
      err_c <= 16'(i);
    end
    @(negedge clk);
    err_v <= 1'b0;
    for (int i = 1; i <= 30; i++)
      rdc(ISR_CMD_ERR_RD, (i == 30) ? `ISR_ERR_OVERFLOW : 16'(i), "error entry");
    rdc(ISR_CMD_ERR_RD, `ISR_ERR_NONE, "error empty");
    // host advisory text plus one error, then device advisory text
    @(negedge clk);
    err_v <= 1'b1;
    adv_wr <= 1'b1;
    adv_host <= 1'b1;
    adv_txt <= 16'h1234;
    @(negedge clk);
    err_v <= 1'b0;
    adv_host <= 1'b0;
    adv_txt <= 16'h5678;
    idle(2);
    adv_wr <= 1'b0;
    rdc(ISR_CMD_MSG_RD, 16'h5678, "advisory text");
    check("message bit", 16'(stb[2]), 16'h0001);
    // output queue level and clear status
    outq <= 1'b1;
    idle(4);
    check("message available", 16'(stb[4]), 16'h0001);
    rdc(ISR_CMD_STB_RD, 16'h0014, "status byte query");
    host.send(ISR_CMD_CLS, 16'h0000, 1'b0);
    idle(3);
    check("message bit cleared", 16'(stb[2]), 16'h0000);
    check("no queue clear", 16'(n_clr), 16'h0000);
    // host-written advisory text alone keeps the message bit low
    @(negedge clk);
    adv_wr <= 1'b1;
    adv_host <= 1'b1;
    adv_txt <= 16'h9abc;
    @(negedge clk);
    adv_wr <= 1'b0;
    adv_host <= 1'b0;
    idle(2);
    check("host text no flag", 16'(stb[2]), 16'h0000);
    rdc(ISR_CMD_MSG_RD, 16'h9abc, "host advisory text");
    rdc(ISR_CMD_ERR_RD, `ISR_ERR_NONE, "errors cleared");
    host.send(ISR_CMD_CLS, 16'h0000, 1'b1);
    idle(3);
    check("queue clear pulse", 16'(n_clr), 16'h0001);
    outq <= 1'b0;
    idle(4);
    check("message available off", 16'(stb[4]), 16'h0000);
    report_and_stop();
  end
endmodule
`default_nettype wire
